// *** inc/dscir_pkg.sv ***
`default_nettype none
package dscir_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;
    localparam logic [7:0] ADDR_IDEAL1 = 8'h27;
    localparam logic [7:0] ADDR_IDEAL2 = 8'h28;
    localparam logic [7:0] ADDR_BETA1 = 8'h29;
    localparam logic [7:0] ADDR_BETA2 = 8'h2a;
    localparam logic [7:0] ADDR_PART_CODE = 8'hed;
    localparam logic [7:0] ADDR_MAKER = 8'hfe;
    localparam logic [7:0] ADDR_DIE_REV = 8'hff;

    // Field widths, positions and reset values
    localparam int NUM_DIODES = 2;
    localparam int NUM_CHANNELS = 3;
    localparam int IDEAL_W = 6;
    localparam int BETA_W = 3;
    localparam int PART_UPPER_W = 6;
    localparam int VARIANT_W = 2;
    localparam int REV_W = 4;
    localparam logic [IDEAL_W-1:0] IDEAL_RST = 6'h12;
    localparam logic [BETA_W-1:0] BETA_RST = 3'h7;
    localparam logic [BETA_W-1:0] BETA_OFF = 3'h7;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Per-diode address tables, index 0 is diode 1
    localparam logic [NUM_DIODES-1:0][7:0] ADDR_IDEAL = {ADDR_IDEAL2, ADDR_IDEAL1};
    localparam logic [NUM_DIODES-1:0][7:0] ADDR_BETA = {ADDR_BETA2, ADDR_BETA1};

    // Timing of one channel measurement slot
    localparam int CLK_PERIOD_NS = 5;
    localparam int CHAN_TIME_NS = 80;
    localparam logic [7:0] CHAN_CYCLES =
        8'((CHAN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] LAST_CHANNEL = 2'(NUM_CHANNELS - 1);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dscir_req_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } dscir_state_e;
endpackage
`default_nettype wire

// *** rtl/dscir_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A write to the one-shot address in standby with no pass running starts one conversion whatever the data byte.
// - The byte written to the one-shot address is thrown away, never stored.
// - Reading the one-shot address always returns zero.
// - Each diode has a read/write six-bit ideality code, upper two bits zero, reset to 12h.
// - Each diode has a three-bit beta range resetting to all ones; any other value turns compensation on.
// - A read-only part code register has fixed upper six bits and a two-bit address variant.
// - A read-only eight-bit maker code register returns a fixed value.
// - A read-only revision register holds a four-bit die revision with upper bits zero.
// - Unassigned addresses read as zero and writes to them change nothing.
module dscir_regs
    import dscir_pkg::*;
#(
    // Identity values below are arbitrary
    parameter logic [PART_UPPER_W-1:0] PART_CODE_UPPER = 6'h2a,
    parameter logic [VARIANT_W-1:0] PART_VARIANT = 2'h0,
    parameter logic [7:0] MAKER_CODE = 8'ha5,
    parameter logic [REV_W-1:0] DIE_REV = 4'h3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire dscir_req_s req,
    input wire logic standby,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic conv_start,
    output logic [1:0] active_channel,
    output logic [NUM_DIODES-1:0][IDEAL_W-1:0] ideality_code,
    output logic [NUM_DIODES-1:0][BETA_W-1:0] beta_range,
    output logic [NUM_DIODES-1:0] beta_comp_en
);
    dscir_state_e state;
    logic [7:0] slot_count;
    logic [7:0] next_rd_data;
    logic one_shot_hit;
    logic addr_mapped;

    // Data byte is never looked at here
    assign one_shot_hit = clk_en && req.wr && (req.addr == ADDR_ONE_SHOT);
    assign busy = (state == ST_CONV);

    for (genvar i = 0; i < NUM_DIODES; i++) begin : g_diode
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                ideality_code[i] <= IDEAL_RST;
            end else if (clk_en && req.wr && req.addr == ADDR_IDEAL[i]) begin
                // Reserved codes are stored as written; keeping them out is the host's job
                ideality_code[i] <= req.wdata[IDEAL_W-1:0];
            end
        end
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                beta_range[i] <= BETA_RST;
            end else if (clk_en && req.wr && req.addr == ADDR_BETA[i]) begin
                beta_range[i] <= req.wdata[BETA_W-1:0];
            end
        end
        assign beta_comp_en[i] = (beta_range[i] != BETA_OFF);
    end

    always_comb begin
        next_rd_data = READ_ZERO;
        addr_mapped = 1'b1;
        case (req.addr)
            ADDR_ONE_SHOT: next_rd_data = READ_ZERO;
            ADDR_IDEAL1: next_rd_data = {2'h0, ideality_code[0]};
            ADDR_IDEAL2: next_rd_data = {2'h0, ideality_code[1]};
            ADDR_BETA1: next_rd_data = {5'h00, beta_range[0]};
            ADDR_BETA2: next_rd_data = {5'h00, beta_range[1]};
            ADDR_PART_CODE: next_rd_data = {PART_CODE_UPPER, PART_VARIANT};
            ADDR_MAKER: next_rd_data = MAKER_CODE;
            ADDR_DIE_REV: next_rd_data = {4'h0, DIE_REV};
            default: begin
                next_rd_data = READ_ZERO;
                addr_mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data <= READ_ZERO;
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= req.rd;
            if (req.rd) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // One-shot outside standby or during a pass is dropped, so passes never overlap
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            slot_count <= 8'h00;
            active_channel <= 2'h0;
            conv_start <= 1'b0;
        end else if (clk_en) begin
            conv_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (one_shot_hit && standby) begin
                        state <= ST_CONV;
                        conv_start <= 1'b1;
                        slot_count <= 8'h00;
                        active_channel <= 2'h0;
                    end
                end
                ST_CONV: begin
                    if (slot_count == CHAN_CYCLES - 8'h01) begin
                        slot_count <= 8'h00;
                        if (active_channel == LAST_CHANNEL) begin
                            state <= ST_IDLE;
                            active_channel <= 2'h0;
                        end else begin
                            active_channel <= active_channel + 2'h1;
                        end
                    end else begin
                        slot_count <= slot_count + 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    localparam logic [7:0] PASS_LEN = 8'(NUM_CHANNELS) * CHAN_CYCLES;
    logic [7:0] busy_len;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_len <= 8'h00;
        end else if (clk_en) begin
            busy_len <= conv_start ? 8'h01 : (busy ? busy_len + 8'h01 : busy_len);
        end
    end

    // One-shot command and measurement pass
    oneshot_start_a: assert property (@(posedge clock) disable iff (rst)
        one_shot_hit && standby && !busy |=> busy && conv_start)
        else $error("one-shot in standby did not start a pass");

    oneshot_nostore_a: assert property (@(posedge clock) disable iff (rst)
        one_shot_hit |=> $stable(ideality_code) && $stable(beta_range))
        else $error("one-shot write changed stored state");

    oneshot_read_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.rd && req.addr == ADDR_ONE_SHOT |=> rd_valid && rd_data == 8'h00)
        else $error("one-shot address read not zero");

    oneshot_refused_a: assert property (@(posedge clock) disable iff (rst)
        one_shot_hit && (!standby || busy) |=> !conv_start)
        else $error("refused one-shot started a pass");

    start_pulse_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && conv_start |-> (busy && active_channel == 2'h0) ##1 !conv_start)
        else $error("pass start pulse wrong");

    channel_step_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && busy && slot_count == CHAN_CYCLES - 8'h01 && active_channel != LAST_CHANNEL
        |=> active_channel == $past(active_channel) + 2'h1)
        else $error("channel did not advance at slot end");

    pass_length_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && $fell(busy) |-> busy_len == PASS_LEN)
        else $error("pass length wrong");

    // Register reads and writes
    ideal_write_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.wr && req.addr == ADDR_IDEAL1
        |=> ideality_code[0] == 6'($past(req.wdata)))
        else $error("ideality write not stored");

    ideal_read_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.rd && req.addr == ADDR_IDEAL2 |=> rd_data[7:6] == 2'h0
        && rd_data[5:0] == $past(ideality_code[1]))
        else $error("ideality read wrong");

    beta_enable_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.wr && req.addr == ADDR_BETA1 && req.wdata[2:0] != 3'h7
        |=> beta_comp_en[0] ##1 (beta_comp_en[0] || $changed(beta_range[0])))
        else $error("beta compensation not enabled");

    beta_write_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.wr && req.addr == ADDR_BETA2
        |=> beta_range[1] == 3'($past(req.wdata)))
        else $error("beta range write not stored");

    part_code_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.rd && req.addr == ADDR_PART_CODE
        |=> rd_data == {PART_CODE_UPPER, PART_VARIANT})
        else $error("part code wrong");

    maker_code_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.rd && req.addr == ADDR_MAKER |=> rd_data == MAKER_CODE)
        else $error("maker code wrong");

    die_rev_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.rd && req.addr == ADDR_DIE_REV |=> rd_data == {4'h0, DIE_REV})
        else $error("revision wrong");

    unmapped_read_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.rd && !addr_mapped |=> rd_data == 8'h00)
        else $error("unmapped read not zero");

    unmapped_write_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && req.wr && !addr_mapped && !busy
        |=> $stable(ideality_code) && $stable(beta_range) && !busy)
        else $error("unmapped write changed state");

    rd_pulse_a: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> rd_valid == $past(req.rd))
        else $error("read valid not one cycle after request");

    // Low clock enable must hold everything, pass counters included
    clk_freeze_a: assert property (@(posedge clock) disable iff (rst)
        !clk_en |=> $stable(ideality_code) && $stable(beta_range) && $stable(rd_data)
        && $stable(rd_valid) && $stable(state) && $stable(slot_count) && $stable(conv_start))
        else $error("state moved while clock enable low");

    pass_start_c: cover property (@(posedge clock) disable iff (rst) conv_start);
    pass_end_c: cover property (@(posedge clock) disable iff (rst) $fell(busy));
    beta_on_c: cover property (@(posedge clock) disable iff (rst) beta_comp_en[1]);
    busy_oneshot_c: cover property (@(posedge clock) disable iff (rst) busy && one_shot_hit);
    refused_c: cover property (@(posedge clock) disable iff (rst) one_shot_hit && !standby);
endmodule
`default_nettype wire

// *** verif/dscir_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dscir_host_model
    import dscir_pkg::*;
(
    input wire logic clock,
    output var dscir_req_s req
);
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

    // Idle address and data keep moving so a stale byte never looks valid
    always @(posedge clock) begin
        if (!req.wr && !req.rd) begin
            req.addr <= ~req.addr;
            req.wdata <= req.wdata + 8'h5b;
        end
    end

    // One byte access, held until the taking edge, released just after it
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/tb_diode_sensor_config_id_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_diode_sensor_config_id_regs
    import dscir_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b1;
    logic clk_en = 1'b1;
    dscir_req_s req;
    logic [7:0] rd_data;
    logic rd_valid, busy, conv_start;
    logic [1:0] active_channel;
    logic [NUM_DIODES-1:0][IDEAL_W-1:0] ideality_code;
    logic [NUM_DIODES-1:0][BETA_W-1:0] beta_range;
    logic [NUM_DIODES-1:0] beta_comp_en;
    int fail_count = 0;
    int cmp_count = 0;
    int n;
    logic [7:0] ids [3] = '{ADDR_PART_CODE, ADDR_MAKER, ADDR_DIE_REV};
    logic [7:0] idv [3] = '{8'ha8, 8'ha5, 8'h03};

    always #2.5 clock = ~clock;

    dscir_regs u_dscir_regs (.clock(clock), .rst(rst), .clk_en(clk_en), .req(req),
        .standby(standby), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
        .conv_start(conv_start), .active_channel(active_channel),
        .ideality_code(ideality_code), .beta_range(beta_range),
        .beta_comp_en(beta_comp_en));
    dscir_host_model u_dscir_host_model (.clock(clock), .req(req));

    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_dscir_host_model.access(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_dscir_host_model.access(1'b0, a, 8'h00);
        chk("rd_valid", 16'h1, 16'(rd_valid));
        chk("rd_data", 16'(e), 16'(rd_data));
    endtask

    // Whole run is a few hundred cycles
    initial begin
        #(5 * 3000);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clock);
        #1 rst = 1'b0;
        wr(8'h10, 8'h4b);
        rd(8'h10, 8'h00);
        chk("beta_comp_en", 16'h0, 16'(beta_comp_en));
        for (int i = 0; i < 2; i++) begin
            rd(ADDR_IDEAL[i], 8'h12);
            rd(ADDR_BETA[i], 8'h07);
        end
        for (int i = 0; i < 3; i++) begin
            wr(ids[i], 8'h5a);
            rd(ids[i], idv[i]);
        end
        // Upper two bits are unused, so a listed code with them set stays legal
        wr(ADDR_IDEAL1, 8'hf1);
        wr(ADDR_IDEAL2, 8'h15);
        rd(ADDR_IDEAL1, 8'h31);
        rd(ADDR_IDEAL2, 8'h15);
        // Write with the clock enable low must be lost
        clk_en = 1'b0;
        wr(ADDR_IDEAL1, 8'h08);
        clk_en = 1'b1;
        chk("ideality_code", 16'h0571, 16'(ideality_code));
        for (int b = 0; b < 8; b++) begin
            wr(ADDR_BETA1, 8'hf8 | 8'(b));
            wr(ADDR_BETA2, 8'hf8 | 8'(7 - b));
            rd(ADDR_BETA1, 8'(b));
            rd(ADDR_BETA2, 8'(7 - b));
            chk("beta_range", 16'({3'(7 - b), 3'(b)}), 16'(beta_range));
            chk("beta_comp_en", 16'({b != 0, b != 7}), 16'(beta_comp_en));
        end
        standby = 1'b0;
        wr(ADDR_ONE_SHOT, 8'h00);
        chk("busy", 16'h0, 16'(busy));
        standby = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_ONE_SHOT, k ? 8'hff : 8'h00);
            chk("conv_start", 16'h1, 16'(conv_start));
            chk("busy", 16'h1, 16'(busy));
            wr(ADDR_ONE_SHOT, 8'h77);
            n = 2;
            while (busy === 1'b1 && n < 100) begin
                @(posedge clock);
                #1 n++;
                if (n == 16 || n == 32) chk("active_channel", 16'(n / 16), 16'(active_channel));
            end
            chk("busy_cycles", 16'd48, 16'(n));
            chk("active_channel", 16'h0, 16'(active_channel));
            rd(ADDR_ONE_SHOT, 8'h00);
        end
        close_out();
    end
endmodule
`default_nettype wire
